/* File: common/srq_map.svh */
/*
  constants for the status reporting and queue block: field positions,
  reset values and queue sizes. assumes inclusion by bare name.
*/
`ifndef SRQ_MAP_SVH
`define SRQ_MAP_SVH
`define SRQ_STB_OPER_BIT    7
`define SRQ_STB_MSS_BIT     6
`define SRQ_STB_ESB_BIT     5
`define SRQ_STB_MAV_BIT     4
`define SRQ_STB_QUES_BIT    3
`define SRQ_STB_ERR_BIT     2
`define SRQ_SES_PON_BIT     7
`define SRQ_SES_CME_BIT     5
`define SRQ_SES_EXE_BIT     4
`define SRQ_SES_DDE_BIT     3
`define SRQ_SES_QYE_BIT     2
`define SRQ_SES_OPC_BIT     0
`define SRQ_SES_USED_MASK   8'hBD
`define SRQ_SES_RESET       8'h80
`define SRQ_ENABLE_RESET    8'h00
`define SRQ_OUT_DEPTH       64
`define SRQ_IN_DEPTH        256
`define SRQ_FIFO_DEPTH      16
`endif

/* File: common/srq_pkg.sv */
/*
  types for the status reporting block.
  assumes srq_map.svh constants are used alongside.
*/
package srq_pkg;
  // link flavour: serial drops data, lan/usb stalls
  typedef enum logic [0:0] {
    SRQ_LINK_SERIAL = 1'b0,
    SRQ_LINK_STALL  = 1'b1
  } srq_link_t;
  // input buffer reception state
  typedef enum logic [0:0] {
    SRQ_IN_OPEN  = 1'b0,
    SRQ_IN_DRAIN = 1'b1
  } srq_in_state_t;
  // event pulses from the command parser
  typedef struct packed {
    logic pwr_fail;
    logic cmd_err;
    logic exe_err;
    logic dev_err;
    logic opc_done;
  } srq_events_t;
  // commands from the parser
  typedef struct packed {
    logic cls;
    logic stb_query;
    logic ses_query;
    logic serial_poll;
    logic err_query;
    logic sre_write;
    logic ses_en_write;
  } srq_cmds_t;
endpackage

/* File: rtl/srq_fifo.sv */
/*
  synchronous fifo with valid/ready on both sides and a flush input.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module srq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage array
  logic [AW-1:0]    wr_ptr;        // write index
  logic [AW-1:0]    rd_ptr;        // read index
  logic [AW:0]      count;         // fill level
  logic             push;
  logic             pop;
  // full when the level reaches the depth
  assign in_ready  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;
  assign level     = count;
  // pointer and level update; flush wins so a cleared queue really empties
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // srq_fifo

/* File: rtl/srq_status.sv */
/*
  status reporting and queue block: output queue, input buffer, status byte,
  service request enable, standard event status and its enable.
  assumes a command parser drives the command and event pulses, one per cycle,
  and the operation and questionable groups supply their summary bits.
*/
`timescale 1ns/1ps
`include "srq_map.svh"
module srq_status import srq_pkg::*; #(
  parameter int OUT_DEPTH = `SRQ_OUT_DEPTH,
  parameter int IN_DEPTH  = `SRQ_IN_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire srq_link_t   link_mode,
  input  wire srq_cmds_t   cmds,
  input  wire srq_events_t events,
  input  wire logic [7:0]  wdata,
  input  wire logic        operation_summary_bit,
  input  wire logic        questionable_summary_bit,
  input  wire logic        error_pending,
  input  wire logic        terminator_seen,
  input  wire logic [7:0]  resp_data,
  input  wire logic        resp_valid,
  output logic             resp_ready,
  output logic [7:0]       out_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       cmd_data,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic             skip_input,
  output logic [7:0]       rdata,
  output logic             rdata_valid,
  output logic             service_request
);
  // registered state of the block outside its three fifos
  typedef struct packed {
    logic [7:0]    sre;
    logic [7:0]    ses;
    logic [7:0]    ses_en;
    logic          mss;
    logic          rqs;
    logic [7:0]    summary_q;
    logic          skip;
    srq_in_state_t in_st;
    logic          flush_out;
    logic [7:0]    rdata;
    logic          rdata_valid;
    logic          srq;
    logic [7:0]    out_data;
    logic          out_valid;
    logic [7:0]    cmd_data;
    logic          cmd_valid;
    logic          resp_ready;
    logic          rx_ready;
  } srq_state_t;
  srq_state_t st;
  srq_state_t next_st;
  localparam int OW = $clog2(OUT_DEPTH);
  localparam int IW = $clog2(IN_DEPTH);
  logic [OW:0]  out_level;    // output queue fill
  logic [IW:0]  in_level;     // input buffer fill
  logic         oq_in_ready;  // output queue accepts a byte
  logic [7:0]   oq_data;
  logic         oq_valid;
  logic         ib_in_ready;  // input buffer accepts a byte
  logic [7:0]   ib_data;
  logic         ib_valid;
  logic         rx_push;      // byte offered to input buffer
  logic [7:0]   fb_data;      // staging fifo toward the parser
  logic         fb_valid;
  logic         fb_in_ready;
  logic         ib_pop;
  logic         oq_pop;
  logic [7:0]   stb_now;      // live status byte
  logic         overflow;     // response arrives with queue full
  // output queue sized for a whole response
  // a byte enters only while resp_ready stands, so a stalled query keeps it
  srq_fifo #(.WIDTH(8), .DEPTH(OUT_DEPTH)) u_out_queue (
    .clk       (clk),
    .reset     (reset),
    .flush     (st.flush_out),
    .in_data   (resp_data),
    .in_valid  (resp_valid && st.resp_ready),
    .in_ready  (oq_in_ready),
    .out_data  (oq_data),
    .out_valid (oq_valid),
    .out_ready (oq_pop),
    .level     (out_level)
  );
  // input buffer of at least 256 characters
  srq_fifo #(.WIDTH(8), .DEPTH(IN_DEPTH)) u_in_buffer (
    .clk       (clk),
    .reset     (reset),
    .flush     (1'b0),
    .in_data   (rx_data),
    .in_valid  (rx_push),
    .in_ready  (ib_in_ready),
    .out_data  (ib_data),
    .out_valid (ib_valid),
    .out_ready (ib_pop),
    .level     (in_level)
  );
  // 16-word staging fifo between input buffer and parser; parser can stall it
  srq_fifo #(.WIDTH(8), .DEPTH(`SRQ_FIFO_DEPTH)) u_cmd_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (1'b0),
    .in_data   (ib_data),
    .in_valid  (ib_valid),
    .in_ready  (fb_in_ready),
    .out_data  (fb_data),
    .out_valid (fb_valid),
    .out_ready (!st.cmd_valid || cmd_ready),
    .level     ()
  );
  assign ib_pop  = ib_valid && fb_in_ready;
  // output register slice toward the controller
  // no byte may slip into the slice while an overflow is emptying the queue
  assign oq_pop  = oq_valid && (!st.out_valid || out_ready) && !st.flush_out && !overflow;
  // serial link writes regardless (overrun lost); stall link gated by state
  assign rx_push = rx_valid && ((link_mode == SRQ_LINK_SERIAL) || st.rx_ready);
  // byte offered on a full queue is overflow on the serial link
  assign overflow = resp_valid && !oq_in_ready && (link_mode == SRQ_LINK_SERIAL);
  // status byte assembly
  always_comb begin
    stb_now = 8'h00;
    // summary bits from the outer groups
    stb_now[`SRQ_STB_OPER_BIT] = operation_summary_bit;
    stb_now[`SRQ_STB_QUES_BIT] = questionable_summary_bit;
    stb_now[`SRQ_STB_ESB_BIT]  = |(st.ses & st.ses_en);
    stb_now[`SRQ_STB_MAV_BIT]  = oq_valid || st.out_valid;
    // error queue pending, cleared outside by the error query
    stb_now[`SRQ_STB_ERR_BIT]  = error_pending;
  end
  // next-state logic
  always_comb begin
    logic [7:0] rise;
    logic [7:0] set_ev;
    next_st = st;
    rise    = 8'h00;
    set_ev  = 8'h00;
    next_st.rdata_valid = 1'b0;
    next_st.flush_out   = 1'b0;
    if (cmds.sre_write) begin
      next_st.sre = wdata & ~(8'h01 << `SRQ_STB_MSS_BIT);
    end
    if (cmds.ses_en_write) begin
      next_st.ses_en = wdata;
    end
    // rising edge of an enabled status bit
    rise = stb_now & ~st.summary_q & st.sre;
    next_st.summary_q = stb_now;
    set_ev[`SRQ_SES_PON_BIT] = events.pwr_fail;
    set_ev[`SRQ_SES_CME_BIT] = events.cmd_err;
    set_ev[`SRQ_SES_EXE_BIT] = events.exe_err;
    set_ev[`SRQ_SES_DDE_BIT] = events.dev_err;
    set_ev[`SRQ_SES_QYE_BIT] = overflow;
    set_ev[`SRQ_SES_OPC_BIT] = events.opc_done;
    // clear by clear-status or query, new events win
    if (cmds.cls || cmds.ses_query) begin
      next_st.ses = 8'h00;
    end
    next_st.ses = (next_st.ses | set_ev) & `SRQ_SES_USED_MASK;
    // query error empties the output queue
    if (overflow) begin
      next_st.flush_out = 1'b1;
      next_st.out_valid = 1'b0;
    end
    // summary held until clear-status; sets it
    if (cmds.cls) begin
      next_st.mss = 1'b0;
      next_st.rqs = 1'b0;
    end
    if (cmds.serial_poll) begin
      next_st.rqs = 1'b0;
    end
    if (|rise) begin
      next_st.mss = 1'b1;
      next_st.rqs = 1'b1;
    end
    next_st.srq = next_st.rqs;
    // register reads
    if (cmds.serial_poll) begin
      // full byte with request bit, returned before clear
      next_st.rdata = stb_now | ({7'h00, st.rqs} << `SRQ_STB_MSS_BIT);
      next_st.rdata_valid = 1'b1;
    end else if (cmds.stb_query) begin
      // query shows summary and does not clear it
      next_st.rdata = stb_now | ({7'h00, st.mss} << `SRQ_STB_MSS_BIT);
      next_st.rdata_valid = 1'b1;
    end else if (cmds.ses_query) begin
      next_st.rdata = st.ses;
      next_st.rdata_valid = 1'b1;
    end
    // discard input up to the terminator after a command error
    if (events.cmd_err) begin
      next_st.skip = 1'b1;
    end else if (terminator_seen) begin
      next_st.skip = 1'b0;
    end
    // stall link closes on full, reopens only when drained empty
    case (st.in_st)
      SRQ_IN_OPEN: begin
        if (!ib_in_ready || (rx_push && in_level == (IW+1)'(IN_DEPTH - 1))) begin
          next_st.in_st = SRQ_IN_DRAIN;
        end
      end
      SRQ_IN_DRAIN: begin
        if (in_level == '0) begin
          next_st.in_st = SRQ_IN_OPEN;
        end
      end
      default: next_st.in_st = SRQ_IN_OPEN;
    endcase
    next_st.rx_ready = (next_st.in_st == SRQ_IN_OPEN);
    // stall link holds the query once the queue is one byte short of full
    next_st.resp_ready = (link_mode == SRQ_LINK_SERIAL) ? 1'b1 :
                         (out_level < (OW+1)'(OUT_DEPTH - 1));
    // output slice toward controller
    if (st.out_valid && out_ready) begin
      next_st.out_valid = 1'b0;
    end
    if (oq_pop) begin
      next_st.out_data  = oq_data;
      next_st.out_valid = 1'b1;
    end
    // command slice toward parser
    if (st.cmd_valid && cmd_ready) begin
      next_st.cmd_valid = 1'b0;
    end
    if (fb_valid && (!st.cmd_valid || cmd_ready)) begin
      next_st.cmd_data  = fb_data;
      next_st.cmd_valid = 1'b1;
    end
  end
  // state register; power-up empties queues and sets power-on
  always_ff @(posedge clk) begin
    if (reset) begin
      st        <= '0;
      st.ses    <= `SRQ_SES_RESET;
      st.sre    <= `SRQ_ENABLE_RESET;
      st.ses_en <= `SRQ_ENABLE_RESET;
      st.in_st  <= SRQ_IN_OPEN;
    end else begin
      st <= next_st;
    end
  end
  assign resp_ready      = st.resp_ready;
  assign out_data        = st.out_data;
  assign out_valid       = st.out_valid;
  assign rx_ready        = st.rx_ready;
  assign cmd_data        = st.cmd_data;
  assign cmd_valid       = st.cmd_valid;
  assign skip_input      = st.skip;
  assign rdata           = st.rdata;
  assign rdata_valid     = st.rdata_valid;
  assign service_request = st.srq;
endmodule // srq_status

/* File: testbench/srq_status_properties.sv */
/*
  port checker for srq_status: read answers, skip window, output stall.
  assumes it is bound onto the design top and sees its ports by name.
*/
`timescale 1ns/1ps
module srq_status_properties import srq_pkg::*; (
  input wire logic        clk,
  input wire logic        reset,
  input wire srq_link_t   link_mode,
  input wire srq_cmds_t   cmds,
  input wire srq_events_t events,
  input wire logic        error_pending,
  input wire logic        terminator_seen,
  input wire logic [7:0]  out_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        skip_input,
  input wire logic [7:0]  rdata,
  input wire logic        rdata_valid,
  input wire logic        service_request
);
  // any read taken this cycle
  wire rd_any = cmds.serial_poll | cmds.stb_query | cmds.ses_query;
  // a poll outranks the status query
  wire stb_only = cmds.stb_query & ~cmds.serial_poll;
  // event register read wins only alone
  wire ses_only = cmds.ses_query & ~cmds.serial_poll & ~cmds.stb_query;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a stalled byte must not move or vanish
  sequence s_held;
    out_valid && $stable(out_data);
  endsequence
  property p_read_ans; rd_any |=> rdata_valid; endproperty
  property p_no_ans; !rd_any |=> !rdata_valid; endproperty
  property p_hold; !rd_any |=> $stable(rdata); endproperty
  property p_unused; (cmds.serial_poll | stb_only) |=> rdata[1:0] == 2'h0; endproperty
  property p_err; stb_only && error_pending && $past(error_pending) |=> rdata[2]; endproperty
  property p_ses_zero; ses_only |=> !rdata[6] && !rdata[1]; endproperty
  property p_skip_set; events.cmd_err && !terminator_seen |=> skip_input; endproperty
  property p_skip_end; terminator_seen && !events.cmd_err |=> !skip_input; endproperty
  property p_stall; link_mode == SRQ_LINK_STALL && out_valid && !out_ready |=> s_held; endproperty
  property p_rst; $fell(reset) |-> !service_request && !rdata_valid && !out_valid; endproperty
  a_read_ans: assert property (p_read_ans) else $error("read without answer");
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_unused: assert property (p_unused) else $error("status bits 1-0 set");
  a_err: assert property (p_err) else $error("error bit missing");
  a_ses_zero: assert property (p_ses_zero) else $error("event bits 6 or 1 set");
  a_skip_set: assert property (p_skip_set) else $error("skip not entered");
  a_skip_end: assert property (p_skip_end) else $error("skip not left");
  a_stall: assert property (p_stall) else $error("stalled byte lost");
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
endmodule // srq_status_properties

/* File: testbench/srq_ctrl_model.sv */
/*
  remote controller model: takes response bytes, can stall.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module srq_ctrl_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  output logic            out_ready,
  output logic [7:0]      q [16],
  output int              got
);
  always_ff @(posedge clk) begin
    out_ready <= !reset && !stall;
    if (reset) begin
      got <= 0;
    end else if (out_valid && out_ready) begin
      q[got[3:0]] <= out_data;
      got         <= got + 1;
    end
  end
endmodule // srq_ctrl_model

/* File: testbench/tb_srq_status.sv */
/*
  self-checking bench for srq_status with a controller model.
  assumes small queue depths so stalls come quickly.
*/
`timescale 1ns/1ps
module tb_srq_status import srq_pkg::*; ;
  localparam srq_cmds_t CLS = 7'h40, STB = 7'h20, SES = 7'h10, POLL = 7'h08;
  localparam srq_cmds_t SRE = 7'h02, SESE = 7'h01;
  logic clk, reset, osb, qsb, err, term, rv, xv, cr, stall, rr, xr, ov, cv, skip, dv, srq, ordy, ok;
  srq_link_t   lm;
  srq_cmds_t   cm;
  srq_events_t ev;
  logic [7:0]  wd, rsp, rx, rdat, od, cd;
  logic [7:0]  q [16];
  int          got, ncmd, error_cnt, compares, cyc, n;
  srq_status #(.OUT_DEPTH(4), .IN_DEPTH(8)) i_srq_status (
    .clk(clk), .reset(reset), .link_mode(lm), .cmds(cm), .events(ev), .wdata(wd),
    .operation_summary_bit(osb), .questionable_summary_bit(qsb), .error_pending(err),
    .terminator_seen(term), .resp_data(rsp), .resp_valid(rv), .resp_ready(rr), .out_data(od),
    .out_valid(ov), .out_ready(ordy), .rx_data(rx), .rx_valid(xv), .rx_ready(xr), .cmd_data(cd),
    .cmd_valid(cv), .cmd_ready(cr), .skip_input(skip), .rdata(rdat), .rdata_valid(dv),
    .service_request(srq));
  srq_ctrl_model i_srq_ctrl_model (.clk(clk), .reset(reset), .stall(stall), .out_data(od),
    .out_valid(ov), .out_ready(ordy), .q(q), .got(got));
  // free running clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard and parser side counter
  always @(posedge clk) begin
    cyc++;
    if (cv === 1'b1 && cr === 1'b1) begin
      chk(cd, ncmd[7:0]);
      ncmd++;
    end
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  // read answer lands on the taking edge and is checked half a cycle later
  task automatic rd(input srq_cmds_t c, input logic [7:0] e);
    @(posedge clk) cm <= c;
    @(posedge clk) cm <= '0;
    @(negedge clk) chk({7'h00, dv}, 8'h01);
    chk(rdat, e);
  endtask
  task automatic wr(input srq_cmds_t c, input logic [7:0] d);
    @(posedge clk) begin cm <= c; wd <= d; end
    @(posedge clk) cm <= '0;
  endtask
  task automatic pulse(input srq_events_t e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= '0;
  endtask
  // hold valid until ready is seen, give up after 20 edges
  task automatic push(input bit s, input logic [7:0] d, output logic a);
    int k;
    k = 0;
    @(posedge clk) if (s) begin rx <= d; xv <= 1'b1; end else begin rsp <= d; rv <= 1'b1; end
    @(posedge clk);
    while ((s ? xr : rr) !== 1'b1 && k < 20) begin @(posedge clk); k++; end
    a = (k < 20);
    if (s) xv <= 1'b0; else rv <= 1'b0;
  endtask
  task automatic t_power();
    rd(SES, 8'h80);
    rd(SES, 8'h00);
    rd(STB, 8'h00);
  endtask
  task automatic t_events();
    logic [7:0] e [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h01};
    for (int i = 0; i < 5; i++) begin
      pulse(srq_events_t'(5'h10 >> i));
      rd(SES, e[i]);
    end
    chk({7'h00, skip}, 8'h01);
    @(posedge clk) term <= 1'b1;
    @(posedge clk) term <= 1'b0;
    @(negedge clk) chk({7'h00, skip}, 8'h00);
  endtask
  task automatic t_request();
    wr(SESE, 8'h10);
    wr(SRE, 8'h20);
    pulse(5'h04);
    repeat (4) @(posedge clk);
    @(negedge clk) chk({7'h00, srq}, 8'h01);
    rd(STB, 8'h60);
    rd(POLL, 8'h60);
    repeat (2) @(posedge clk);
    @(negedge clk) chk({7'h00, srq}, 8'h00);
    rd(STB, 8'h60);
    rd(POLL, 8'h20);
    wr(CLS, 8'h00);
    rd(STB, 8'h00);
    @(posedge clk) begin osb <= 1'b1; qsb <= 1'b1; err <= 1'b1; end
    repeat (4) @(posedge clk);
    @(negedge clk) chk({7'h00, srq}, 8'h00);
    rd(STB, 8'h8C);
    @(posedge clk) err <= 1'b0;
    rd(STB, 8'h88);
    @(posedge clk) begin osb <= 1'b0; qsb <= 1'b0; end
  endtask
  task automatic t_outq();
    @(posedge clk) begin lm <= SRQ_LINK_STALL; stall <= 1'b1; end
    for (int i = 0; i < 8; i++) begin
      push(1'b0, 8'hA0 + i[7:0], ok);
      if (!ok) begin
        chk({7'h00, rr}, 8'h00);
        chk({7'h00, i >= 3}, 8'h01);
        rd(STB, 8'h10);
        @(posedge clk) stall <= 1'b0;
        push(1'b0, 8'hA0 + i[7:0], ok);
      end
    end
    repeat (30) @(posedge clk);
    chk(got[7:0], 8'h08);
    for (int j = 0; j < 8; j++) chk(q[j], 8'hA0 + j[7:0]);
    rd(STB, 8'h00);
  endtask
  task automatic t_overflow();
    @(posedge clk) begin lm <= SRQ_LINK_SERIAL; stall <= 1'b1; end
    // five bytes fill slice and queue; the sixth overflows and nothing follows it
    for (int i = 0; i < 6; i++) @(posedge clk) begin rv <= 1'b1; rsp <= i[7:0]; end
    @(posedge clk) rv <= 1'b0;
    repeat (4) @(posedge clk);
    rd(SES, 8'h04);
    rd(STB, 8'h00);
    @(posedge clk) stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(got[7:0], 8'h08);
  endtask
  task automatic t_inbuf();
    @(posedge clk) lm <= SRQ_LINK_STALL;
    n  = 0;
    ok = 1'b1;
    // buffer, staging fifo and slice must all fill before reception stalls
    while (ok && n < 40) begin
      push(1'b1, n[7:0], ok);
      if (ok) n++;
    end
    chk({7'h00, n >= 8}, 8'h01);
    @(posedge clk) cr <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) chk({7'h00, xr}, 8'h00);
    repeat (40) @(posedge clk);
    chk(ncmd[7:0], n[7:0]);
    chk({7'h00, xr}, 8'h01);
  endtask
  // main sequence
  initial begin
    {osb, qsb, err, term, rv, xv, cr, stall} = '0;
    {cm, ev, wd, rsp, rx} = '0;
    {ncmd, error_cnt, compares, cyc} = '0;
    lm    = SRQ_LINK_SERIAL;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_power();
    t_events();
    t_request();
    t_outq();
    t_overflow();
    t_inbuf();
    end_sim();
  end
endmodule // tb_srq_status
bind srq_status srq_status_properties i_srq_status_properties (.*);
